// [gstt_core.sv]
// gated sequence trigger timing core with register port
//
// Implementation choices: the address map and strobed register access.
`include "gstt_defs.svh"
module gstt_core
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// register port
	input wire gstt_pkg::gstt_bus_t bus,
	output logic [31:0] rdData,
	// trigger pin and sensor status
	input wire logic trigIn,
	input wire logic readoutDone,
	// timing outputs
	output gstt_pkg::gstt_pulse_t pulses,
	output logic exposure_active,
	output logic sequence_complete,
	output logic generator_done,
	output logic shiftToStorage,
	output logic readoutStart
);
	import gstt_pkg::*;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] ctrl_ff;
	logic [15:0] count_ff;
	logic [31:0] freq_ff;
	logic [15:0] gate_ff;
	logic [15:0] delay_ff;
	logic countBad_ff;
	logic srcExt_ff;
	logic dual_ff;
	logic pershot_ff;
	gstt_state_t state_ff;
	logic [15:0] done_ff;
	logic [15:0] timer_ff;
	logic shot_ff;
	logic heldImage_ff;
	logic [15:0] gapCnt_ff;
	logic intTick;
	logic extEdge;
	logic trig;
	logic startReq;
	logic dualSel;
	function automatic logic is_write(input gstt_bus_t b, input logic [3:0] a);
		is_write = b.wr && (b.addr == a);
	endfunction
	assign startReq = is_write(bus, `GSTT_ADDR_CTRL) && bus.wdata[`GSTT_CTRL_START];
	assign dualSel = bus.wdata[`GSTT_CTRL_DUAL] && bus.wdata[`GSTT_CTRL_INTERLINE];
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			ctrl_ff <= 8'h00;
			count_ff <= `GSTT_COUNT_RESET;
			freq_ff <= `GSTT_FREQ_RESET;
			gate_ff <= `GSTT_GATE_RESET;
			delay_ff <= 16'h0000;
		end
		else if (state_ff == ST_IDLE)
		begin
			if (is_write(bus, `GSTT_ADDR_CTRL))
				ctrl_ff <= {1'b0, bus.wdata[6:1], 1'b0};
			if (is_write(bus, `GSTT_ADDR_COUNT))
				count_ff <= bus.wdata[15:0];
			if (is_write(bus, `GSTT_ADDR_FREQ))
				freq_ff <= bus.wdata;
			if (is_write(bus, `GSTT_ADDR_GATE))
				gate_ff <= (bus.wdata[15:0] == 16'h0000) ? 16'h0001 : bus.wdata[15:0];
			if (is_write(bus, `GSTT_ADDR_DELAY))
				delay_ff <= bus.wdata[15:0];
		end
	end
	// ----------------------------------------
	// trigger sources
	// ----------------------------------------
	gstt_trig_gen u_gen
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.run(1'b1),
		.freqHz(freq_ff),
		.tick(intTick)
	);
	gstt_trig_in u_in
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.trigPin(trigIn),
		.fallingEdge(ctrl_ff[`GSTT_CTRL_POL]),
		.edgeSeen(extEdge)
	);
	assign trig = srcExt_ff ? extEdge : intTick;
	// ----------------------------------------
	// sequence state machine
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_ff <= ST_IDLE;
			srcExt_ff <= 1'b0;
			dual_ff <= 1'b0;
			pershot_ff <= 1'b0;
			countBad_ff <= 1'b0;
			done_ff <= 16'h0000;
			timer_ff <= 16'h0000;
			shot_ff <= 1'b0;
		end
		else if (is_write(bus, `GSTT_ADDR_CTRL) && bus.wdata[`GSTT_CTRL_ABORT])
			state_ff <= ST_IDLE;
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					if (startReq)
					begin
						countBad_ff <= dualSel && (bus.wdata[0] ? count_ff[0] : 1'b0);
						if (!(dualSel && count_ff[0]) && count_ff != 16'h0000)
						begin
							srcExt_ff <= bus.wdata[`GSTT_CTRL_EXT];
							dual_ff <= dualSel;
							pershot_ff <= bus.wdata[`GSTT_CTRL_PERSHOT];
							done_ff <= 16'h0000;
							shot_ff <= 1'b0;
							state_ff <= ST_WAIT;
						end
					end
				end
				ST_WAIT:
				begin
					if (trig)
					begin
						timer_ff <= delay_ff;
						state_ff <= ST_GATE;
					end
				end
				ST_GATE:
				begin
					// delay then gate width, triggers ignored here
					if (timer_ff != 16'h0000)
						timer_ff <= timer_ff - 16'h0001;
					else if (!pulses.gateStart && !pulses.plateGate)
						timer_ff <= gate_ff;
					else if (pulses.plateGate && timer_ff == 16'h0000)
					begin
						done_ff <= done_ff + 16'h0001;
						if (dual_ff && !shot_ff)
						begin
							state_ff <= ST_SHIFT;
							shot_ff <= 1'b1;
						end
						else if (done_ff + 16'h0001 >= count_ff)
						begin
							timer_ff <= 16'(`GSTT_EXPOSURE_ACTIVE_TAIL_CYC);
							state_ff <= ST_TAIL;
						end
						else
						begin
							shot_ff <= 1'b0;
							state_ff <= ST_WAIT;
						end
					end
				end
				ST_SHIFT:
				begin
					timer_ff <= 16'(`GSTT_PAIR_GAP_CYC);
					state_ff <= ST_GAP;
				end
				ST_GAP:
				begin
					if (timer_ff > 16'h0001)
						timer_ff <= timer_ff - 16'h0001;
					else if (pershot_ff)
						state_ff <= ST_WAIT;
					else
					begin
						timer_ff <= delay_ff;
						state_ff <= ST_GATE;
					end
				end
				ST_TAIL:
				begin
					if (timer_ff > 16'h0001)
						timer_ff <= timer_ff - 16'h0001;
					else
						state_ff <= ST_IDLE;
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// gate edges and exposure
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pulses.plateGate <= 1'b0;
			pulses.gateStart <= 1'b0;
			pulses.gateStop <= 1'b0;
		end
		else
		begin
			pulses.gateStart <= 1'b0;
			pulses.gateStop <= 1'b0;
			if (state_ff == ST_GATE && timer_ff == 16'h0000 && !pulses.plateGate
				&& !pulses.gateStart)
			begin
				pulses.gateStart <= 1'b1;
				pulses.plateGate <= 1'b1;
			end
			else if (state_ff == ST_GATE && pulses.plateGate && timer_ff == 16'h0000)
			begin
				pulses.gateStop <= 1'b1;
				pulses.plateGate <= 1'b0;
			end
			else if (state_ff != ST_GATE)
				pulses.plateGate <= 1'b0;
		end
	end
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			exposure_active <= 1'b0;
		else
			exposure_active <= (state_ff != ST_IDLE && state_ff != ST_TAIL)
				|| (state_ff == ST_TAIL && timer_ff > 16'h0001);
	end
	// ----------------------------------------
	// sync outputs
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pulses.syncPrimary <= 1'b0;
			pulses.syncSecondary <= 1'b0;
		end
		else
		begin
			pulses.syncPrimary <= ctrl_ff[`GSTT_CTRL_SYNC_EN] && intTick;
			pulses.syncSecondary <= pulses.syncPrimary;
		end
	end
	// ----------------------------------------
	// completion, storage shift and readout
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sequence_complete <= 1'b0;
			generator_done <= 1'b0;
			readoutStart <= 1'b0;
			shiftToStorage <= 1'b0;
			heldImage_ff <= 1'b0;
		end
		else
		begin
			shiftToStorage <= (state_ff == ST_SHIFT);
			if (state_ff == ST_SHIFT)
				heldImage_ff <= 1'b1;
			else if (readoutDone)
				heldImage_ff <= 1'b0;
			readoutStart <= (state_ff == ST_TAIL && timer_ff <= 16'h0001);
			if (state_ff == ST_TAIL && timer_ff <= 16'h0001)
			begin
				sequence_complete <= 1'b1;
				generator_done <= 1'b1;
			end
			else if (startReq && state_ff == ST_IDLE)
			begin
				sequence_complete <= 1'b0;
				generator_done <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			rdData <= 32'h00000000;
		else if (bus.rd)
		begin
			case (bus.addr)
				`GSTT_ADDR_CTRL: rdData <= {24'h000000, ctrl_ff};
				`GSTT_ADDR_COUNT: rdData <= {16'h0000, count_ff};
				`GSTT_ADDR_FREQ: rdData <= freq_ff;
				`GSTT_ADDR_GATE: rdData <= {16'h0000, gate_ff};
				`GSTT_ADDR_DELAY: rdData <= {16'h0000, delay_ff};
				`GSTT_ADDR_STATUS: rdData <= {23'h000000, heldImage_ff, countBad_ff,
					sequence_complete, generator_done, exposure_active, 1'b0, state_ff};
				`GSTT_ADDR_DONE: rdData <= {16'h0000, done_ff};
				default: rdData <= 32'h00000000;
			endcase
		end
		else
			rdData <= 32'h00000000;
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	// counts cycles spent in the pair gap
	always_ff @(posedge clock)
	begin
		if (sys_rst || state_ff != ST_GAP)
			gapCnt_ff <= 16'h0000;
		else
			gapCnt_ff <= gapCnt_ff + 16'h0001;
	end
	a_tail_drop: assert property (@(posedge clock) disable iff (sys_rst)
		(state_ff == ST_TAIL && timer_ff <= 16'h0001) |=> ##1 !exposure_active)
		else $error("exposure stays high after tail");
	a_gate_during_exposure_active: assert property (@(posedge clock) disable iff (sys_rst)
		pulses.plateGate |-> exposure_active)
		else $error("gate outside exposure");
	a_stop_ends_gate: assert property (@(posedge clock) disable iff (sys_rst)
		pulses.gateStop |-> !pulses.plateGate && $past(pulses.plateGate))
		else $error("stop edge without gate fall");
	a_done_count: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(sequence_complete) |-> done_ff == count_ff)
		else $error("sequence ended at wrong count");
	a_shift_after_first: assert property (@(posedge clock) disable iff (sys_rst)
		(state_ff == ST_SHIFT) |=> shiftToStorage && shot_ff)
		else $error("no storage shift after first shot");
	a_gap_length: assert property (@(posedge clock) disable iff (sys_rst)
		(gapCnt_ff != 16'h0000 && (state_ff == ST_WAIT || state_ff == ST_GATE))
		|-> gapCnt_ff == 16'(`GSTT_PAIR_GAP_CYC))
		else $error("pair gap has wrong length");
	a_readout_after: assert property (@(posedge clock) disable iff (sys_rst)
		readoutStart |-> ##1 !exposure_active)
		else $error("readout while exposing");
	a_odd_rejected: assert property (@(posedge clock) disable iff (sys_rst)
		(state_ff == ST_IDLE && startReq && dualSel && count_ff[0]) |=> state_ff == ST_IDLE)
		else $error("odd dual count accepted");
	a_sync_rate: assert property (@(posedge clock) disable iff (sys_rst)
		pulses.syncPrimary |-> $past(intTick))
		else $error("sync not from internal tick");
endmodule

// [gstt_defs.svh]
// constants for the gated sequence trigger timing block
`ifndef GSTT_DEFS_SVH
`define GSTT_DEFS_SVH
`define GSTT_CLK_HZ 25000000
`define GSTT_FREQ_MIN_HZ 2
`define GSTT_FREQ_MAX_HZ 1000000
`define GSTT_FREQ_STEP_HZ 1
`define GSTT_EXPOSURE_ACTIVE_TAIL_NS 15
`define GSTT_CLK_PERIOD_NS 40
`define GSTT_EXPOSURE_ACTIVE_TAIL_CYC (((`GSTT_EXPOSURE_ACTIVE_TAIL_NS) / (`GSTT_CLK_PERIOD_NS)) > 0 ? ((`GSTT_EXPOSURE_ACTIVE_TAIL_NS) / (`GSTT_CLK_PERIOD_NS)) : 1)
`define GSTT_PAIR_GAP_NS 450
`define GSTT_PAIR_GAP_CYC (((`GSTT_PAIR_GAP_NS) + (`GSTT_CLK_PERIOD_NS) - 1) / (`GSTT_CLK_PERIOD_NS))
`define GSTT_MIN_GATE_NS 2.5
`define GSTT_MIN_GATE_CYC 1
`define GSTT_ADDR_CTRL 4'h0
`define GSTT_ADDR_COUNT 4'h1
`define GSTT_ADDR_FREQ 4'h2
`define GSTT_ADDR_GATE 4'h3
`define GSTT_ADDR_DELAY 4'h4
`define GSTT_ADDR_STATUS 4'h5
`define GSTT_ADDR_DONE 4'h6
`define GSTT_CTRL_START 0
`define GSTT_CTRL_EXT 1
`define GSTT_CTRL_POL 2
`define GSTT_CTRL_DUAL 3
`define GSTT_CTRL_INTERLINE 4
`define GSTT_CTRL_PERSHOT 5
`define GSTT_CTRL_SYNC_EN 6
`define GSTT_CTRL_ABORT 7
`define GSTT_FREQ_RESET 32'h000003e8
`define GSTT_GATE_RESET 16'h0004
`define GSTT_COUNT_RESET 16'h0001
`endif

// [gstt_pkg.sv]
// types for the gated sequence trigger timing block
package gstt_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} gstt_bus_t;
	typedef struct packed {
		logic plateGate;
		logic gateStart;
		logic gateStop;
		logic syncPrimary;
		logic syncSecondary;
	} gstt_pulse_t;
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_GATE, ST_SHIFT, ST_GAP, ST_TAIL} gstt_state_t;
endpackage

// [gstt_trig_gen.sv]
// internal trigger generator: phase accumulator at 1 hz resolution
`include "gstt_defs.svh"
module gstt_trig_gen
#(
	parameter int ACC_W = 32
)
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// setting
	input wire logic run,
	input wire logic [ACC_W-1:0] freqHz,
	// tick
	output logic tick
);
	logic [ACC_W-1:0] acc_ff;
	logic [ACC_W-1:0] freqClamp;
	logic [ACC_W:0] sum;
	always_comb
	begin
		if (freqHz < ACC_W'(`GSTT_FREQ_MIN_HZ))
			freqClamp = ACC_W'(`GSTT_FREQ_MIN_HZ);
		else if (freqHz > ACC_W'(`GSTT_FREQ_MAX_HZ))
			freqClamp = ACC_W'(`GSTT_FREQ_MAX_HZ);
		else
			freqClamp = freqHz;
		sum = {1'b0, acc_ff} + {1'b0, freqClamp};
	end
	always_ff @(posedge clock)
	begin
		if (sys_rst || !run)
		begin
			acc_ff <= '0;
			tick <= 1'b0;
		end
		else if (sum >= (ACC_W+1)'(`GSTT_CLK_HZ))
		begin
			acc_ff <= ACC_W'(sum - (ACC_W+1)'(`GSTT_CLK_HZ));
			tick <= 1'b1;
		end
		else
		begin
			acc_ff <= ACC_W'(sum);
			tick <= 1'b0;
		end
	end
endmodule

// [gstt_trig_in.sv]
// external trigger input: three-stage synchroniser and edge qualifier
module gstt_trig_in
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// pin and setting
	input wire logic trigPin,
	input wire logic fallingEdge,
	// qualified edge
	output logic edgeSeen
);
	logic [2:0] sync_ff;
	logic level_ff;
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			sync_ff <= 3'h0;
		else
			sync_ff <= {sync_ff[1:0], trigPin};
	end
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			level_ff <= 1'b0;
			edgeSeen <= 1'b0;
		end
		else if (sync_ff[1] == sync_ff[2] && sync_ff[2] != level_ff)
		begin
			level_ff <= sync_ff[2];
			edgeSeen <= (sync_ff[2] != fallingEdge);
		end
		else
			edgeSeen <= 1'b0;
	end
endmodule

// [gstt_far_side_model.sv]
// far side model: external trigger source and sensor readout
module gstt_far_side_model
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// bench control
	input wire logic fire,
	input wire logic fallingEdge,
	// camera side
	input wire logic shiftToStorage,
	output logic trigIn,
	output logic readoutDone
);
	timeunit 1ns;
	timeprecision 1ps;
	int pulseLeft = 0;
	int lag = 0;
	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			pulseLeft <= 0;
			lag <= 0;
		end
		else
		begin
			pulseLeft <= fire ? 4 : (pulseLeft > 0 ? pulseLeft - 1 : 0);
			lag <= shiftToStorage ? 20 : (lag > 0 ? lag - 1 : 0);
		end
	end
	// trigger idles at the inactive level
	assign trigIn = (pulseLeft > 0) ? !fallingEdge : fallingEdge;
	// held image read out some cycles after the shift
	assign readoutDone = (lag == 1);
endmodule

// [gstt_core_tb.sv]
// self-checking bench for the gated sequence trigger timing core
`include "gstt_defs.svh"
`define CHECK(a, b) begin checksDone++; if ((a) !== (b)) begin failCount++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module gstt_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gstt_pkg::*;
	localparam logic [7:0] cGo = 8'h1 << `GSTT_CTRL_START;
	localparam logic [7:0] cExt = 8'h1 << `GSTT_CTRL_EXT;
	localparam logic [7:0] cFall = 8'h1 << `GSTT_CTRL_POL;
	localparam logic [7:0] cDualOnly = 8'h1 << `GSTT_CTRL_DUAL;
	localparam logic [7:0] cDual = cDualOnly | (8'h1 << `GSTT_CTRL_INTERLINE);
	localparam logic [7:0] cShot = 8'h1 << `GSTT_CTRL_PERSHOT;
	localparam logic [7:0] cSync = 8'h1 << `GSTT_CTRL_SYNC_EN;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	gstt_bus_t bus = '0;
	logic [31:0] rdData;
	logic trigIn, readoutDone;
	logic fire = 1'b0;
	logic fallEdge = 1'b0;
	gstt_pulse_t pulses;
	logic exposure_active, sequence_complete, generator_done, shiftToStorage, readoutStart;
	int failCount = 0;
	int checksDone = 0;
	int cyc = 0, nGate = 0, nShift = 0, nRead = 0, nBad = 0, nStop = 0, g0, s0, r0;
	int priT[$];
	int secT[$];
	logic [31:0] lfsr = 32'ha768e108;
	logic [31:0] d;
	logic [3:0] ra[5] = '{`GSTT_ADDR_CTRL, `GSTT_ADDR_COUNT, `GSTT_ADDR_FREQ,
		`GSTT_ADDR_GATE, `GSTT_ADDR_DELAY};
	logic [31:0] rx[5] = '{32'h0, 32'(`GSTT_COUNT_RESET), `GSTT_FREQ_RESET,
		32'(`GSTT_GATE_RESET), 32'h0};

	always #20 clock = ~clock;

	// ----------------
	// device, far side and monitor
	// ----------------
	gstt_core i_gstt_core
	(
		.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdData(rdData), .trigIn(trigIn),
		.readoutDone(readoutDone), .pulses(pulses), .exposure_active(exposure_active),
		.sequence_complete(sequence_complete), .generator_done(generator_done),
		.shiftToStorage(shiftToStorage), .readoutStart(readoutStart)
	);
	gstt_far_side_model i_gstt_far_side_model
	(
		.clock(clock), .sys_rst(sys_rst), .fire(fire), .fallingEdge(fallEdge),
		.shiftToStorage(shiftToStorage), .trigIn(trigIn), .readoutDone(readoutDone)
	);
	always @(posedge clock)
	begin
		cyc++;
		nGate += int'(pulses.gateStart === 1'b1);
		nStop += int'(pulses.gateStop === 1'b1);
		nBad += int'(pulses.plateGate === 1'b1 && exposure_active !== 1'b1);
		nShift += int'(shiftToStorage === 1'b1);
		nRead += int'(readoutStart === 1'b1);
		nBad += int'(pulses.gateStart === 1'b1 && exposure_active !== 1'b1);
		nBad += int'(readoutStart === 1'b1 && exposure_active !== 1'b0);
		if (pulses.syncPrimary === 1'b1)
			priT.push_back(cyc);
		if (pulses.syncSecondary === 1'b1)
			secT.push_back(cyc);
	end

	// ----------------
	// tasks
	// ----------------
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic busWrite(input logic [3:0] a, input logic [31:0] v);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic busRead(input logic [3:0] a, output logic [31:0] v);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		@(posedge clock);
		v = rdData;
	endtask
	task automatic fireTrig();
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		@(posedge clock);
	endtask
	task automatic runSeq(input logic [7:0] ctrl, input int count, trigs, gap, gate);
		lfsr = nextRand(lfsr);
		fallEdge <= ctrl[`GSTT_CTRL_POL];
		g0 = nGate;
		s0 = nShift;
		r0 = nRead;
		busWrite(`GSTT_ADDR_COUNT, 32'(count));
		busWrite(`GSTT_ADDR_GATE, 32'(gate > 0 ? gate : int'(lfsr[3:2]) + 1));
		busWrite(`GSTT_ADDR_DELAY, {30'h0, lfsr[1:0]});
		busWrite(`GSTT_ADDR_FREQ, 32'h001e8480);
		busWrite(`GSTT_ADDR_CTRL, {24'h0, ctrl});
		repeat (trigs)
		begin
			repeat (gap) @(posedge clock);
			fireTrig();
		end
	endtask
	task automatic endSeq(input int count, input bit dual);
		int n;
		n = 0;
		@(posedge clock);
		while (sequence_complete !== 1'b1 && n < 3000)
		begin
			@(posedge clock);
			n++;
		end
		repeat (2) @(posedge clock);
		`CHECK(n < 3000, 1'b1)
		`CHECK(nGate - g0, count)
		`CHECK(nShift - s0, dual ? count / 2 : 0)
		`CHECK(nRead - r0, 1)
		`CHECK(exposure_active, 1'b0)
		`CHECK(generator_done, 1'b1)
		busRead(`GSTT_ADDR_DONE, d);
		`CHECK(d, 32'(count))
		$display("test done at %0t", $time);
	endtask
	task automatic giveVerdict();
		$display("counts: %0d checks, %0d mismatches", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------
	// test sequence
	// ----------------
	initial
	begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
		foreach (ra[i])
		begin
			busRead(ra[i], d);
			`CHECK(d, rx[i])
		end
		busRead(4'hf, d);
		`CHECK(d, 32'h00000000)
		busWrite(`GSTT_ADDR_FREQ, 32'h1);
		busRead(`GSTT_ADDR_FREQ, d);
		`CHECK(d, 32'h00000001)
		busWrite(`GSTT_ADDR_FREQ, 32'h001e8480);
		busRead(`GSTT_ADDR_FREQ, d);
		`CHECK(d, 32'h001e8480)
		$display("test done at %0t", $time);
		runSeq(cGo, 3, 0, 0, 0);
		endSeq(3, 0);
		runSeq(cGo | cExt, 2, 2, 60, 0);
		endSeq(2, 0);
		runSeq(cGo | cExt | cFall, 2, 2, 60, 0);
		endSeq(2, 0);
		runSeq(cGo | cExt, 2, 2, 4, 40);
		repeat (80) @(posedge clock);
		`CHECK(sequence_complete, 1'b0)
		fireTrig();
		endSeq(2, 0);
		runSeq(cGo | cSync, 2, 0, 0, 0);
		endSeq(2, 0);
		`CHECK(priT.size() > 1, 1'b1)
		`CHECK(priT[1] - priT[0], `GSTT_CLK_HZ / `GSTT_FREQ_MAX_HZ)
		`CHECK(secT[0] - priT[0], 1)
		runSeq(cGo | cDualOnly, 2, 0, 0, 0);
		endSeq(2, 0);
		runSeq(cGo | cExt | cDual, 2, 1, 10, 0);
		endSeq(2, 1);
		runSeq(cGo | cExt | cDual | cShot, 2, 1, 10, 0);
		repeat (100) @(posedge clock);
		`CHECK(sequence_complete, 1'b0)
		fireTrig();
		endSeq(2, 1);
		runSeq(cGo | cDual, 4, 0, 0, 0);
		endSeq(4, 1);
		runSeq(cGo | cDual, 3, 0, 0, 0);
		repeat (200) @(posedge clock);
		`CHECK(nGate - g0, 0)
		`CHECK(exposure_active, 1'b0)
		`CHECK(nBad, 0)
		`CHECK(nStop, nGate)
		$display("test done at %0t", $time);
		giveVerdict();
	end
	initial
	begin
		#(40 * 30000);
		failCount++;
		giveVerdict();
	end
endmodule
